//--- logic/uarx_core.sv
// Purpose: asynchronous receive path with oversampling and a status buffer
// Assumes: SAMPLE_TICK pulses once per oversample period, one cycle wide
// Notes:   all outputs are registered; all but RXD_OVERRIDE lag the buffer by one cycle
//
// Contract
// R01: each buffered frame keeps its own status
// R02: software reads status before data
// R03: error flags not writable by software
// R04: error flags never raise interrupts
// R05: stop error is inverse of stop sample
// R06: only first stop bit is checked
// R07: overrun on full buffer, pending char, start
// R08: overrun cleared on transfer into buffer
// R09: parity enable and odd/even select
// R10: parity compared and stored with frame
// R11: parity error only when checking enabled
// R12: disable stops reception and releases pin
// R13: disable empties the receive buffer
// R14: software flushes by reading until empty
// R15: sixteen or eight samples per bit
// R16: start bit voted at samples 8-10/4-6
// R17: majority high rejects start as noise
// R18: sixteen or eight bit states numbered
// R19: three centre samples voted per bit
// R20: frame ends at first stop bit
// R21: normal mode rearms after last vote
// R22: receive complete tracks unread characters
// R23: double speed rearms one tick later
// R24: input synchronised, counter moves on ticks
`timescale 1ns/1ps
module uarx_core (
  input  wire logic                      CORE_CLK,
  input  wire logic                      RESET_N,
  input  wire logic                      RXD_PIN,
  input  wire logic                      SAMPLE_TICK,
  input  wire logic                      RECEIVER_ENABLE_BIT,
  input  wire logic                      DOUBLE_SPEED_SELECT,
  input  wire logic                      PARITY_ENABLE_BIT,
  input  wire logic                      PARITY_ODD_SELECT,
  input  wire logic                      DATA_READ,
  output logic [uarx_pkg::UARX_DATA_W-1:0] DATA_BUFFER_LOCATION,
  output logic                           STOP_BIT_ERROR_FLAG,
  output logic                           OVERRUN_FLAG,
  output logic                           PARITY_ERROR_FLAG,
  output logic                           RECEIVE_COMPLETE_FLAG,
  output logic                           RXD_OVERRIDE
);
  import uarx_pkg::*;

  localparam logic [3:0] LAST_IDX = 4'(UARX_DATA_W - 1);

  uarx_buf_if buf_bus ();

  logic           smp;
  uarx_state_type state_ff,   nxt_state;
  logic [4:0]     cnt_ff,     nxt_cnt;
  logic [3:0]     idx_ff;
  logic [1:0]     vote_ff;
  logic           last_ff;
  logic [UARX_DATA_W-1:0] shift_ff;
  logic           par_bit_ff;
  uarx_entry_type pend_ff;
  logic           pend_ok_ff;
  logic           lose_ff;

  // input synchroniser
  uarx_sync u_sync ( // R24
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .din   (RXD_PIN),
    .dout  (smp)
  );

  // two-entry receive buffer
  uarx_rxbuf #(.DEPTH(2)) u_buf (
    .clk   (CORE_CLK),
    .rst_n (RESET_N),
    .bus   (buf_bus)
  );

  // mode-dependent sample numbers
  wire       en        = RECEIVER_ENABLE_BIT;
  wire [4:0] bit_last  = DOUBLE_SPEED_SELECT ? UARX_LAST_DBL  : UARX_LAST_NORM;  // R15 R18
  wire [4:0] vote_1st  = DOUBLE_SPEED_SELECT ? UARX_VOTE1_DBL : UARX_VOTE1_NORM; // R16
  wire [4:0] vote_end  = DOUBLE_SPEED_SELECT ? UARX_VOTEN_DBL : UARX_VOTEN_NORM; // R16
  wire       tick      = SAMPLE_TICK && en; // R24
  wire       in_window = tick && cnt_ff >= vote_1st && cnt_ff < vote_end;
  wire       at_vote   = tick && cnt_ff == vote_end;
  wire       at_end    = tick && cnt_ff == bit_last;
  // majority of the two held centre samples and the current one
  wire       maj = (vote_ff[0] & vote_ff[1]) | (smp & (vote_ff[0] | vote_ff[1])); // R19

  // frame events
  wire start_det  = tick && state_ff == UARX_IDLE && last_ff && !smp;
  wire frame_done = at_vote && state_ff == UARX_STOP; // R20 R06
  wire overrun    = start_det && pend_ok_ff && buf_bus.full; // R07
  wire transfer   = pend_ok_ff && !buf_bus.full && en;

  // parity of data and received parity bit, odd or even sense
  wire par_sum = ^shift_ff ^ par_bit_ff; // R10
  wire par_bad = PARITY_ODD_SELECT ? !par_sum : par_sum; // R09

  // recovery state machine
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    if (tick) begin
      nxt_cnt = (cnt_ff >= bit_last) ? UARX_SAMPLE_ONE : cnt_ff + 5'h01; // R18
    end
    unique case (state_ff)
      UARX_IDLE: begin
        if (start_det) begin // R16
          nxt_state = UARX_START;
          nxt_cnt   = UARX_SAMPLE_ONE;
        end
      end
      UARX_START: begin
        if (at_vote && maj) nxt_state = UARX_IDLE; // R17
        else if (at_end) nxt_state = UARX_DATA;
      end
      UARX_DATA: begin
        if (at_end && idx_ff == LAST_IDX) begin
          nxt_state = PARITY_ENABLE_BIT ? UARX_PARITY : UARX_STOP;
        end
      end
      UARX_PARITY: begin
        if (at_end) nxt_state = UARX_STOP;
      end
      UARX_STOP: begin
        if (frame_done) nxt_state = DOUBLE_SPEED_SELECT ? UARX_HOLD : UARX_IDLE; // R21 R23
      end
      UARX_HOLD: begin
        if (tick) nxt_state = UARX_IDLE; // R23
      end
      default: nxt_state = UARX_IDLE;
    endcase
    if (!en) begin // R12
      nxt_state = UARX_IDLE;
      nxt_cnt   = UARX_SAMPLE_ONE;
    end
  end

  // state, counter and last sample seen
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_ff <= UARX_IDLE;
      cnt_ff   <= UARX_SAMPLE_ONE;
      last_ff  <= UARX_LINE_IDLE;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
      if (tick) last_ff <= smp;
      else if (!en) last_ff <= UARX_LINE_IDLE;
    end
  end

  // centre samples, data bits and parity bit
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      vote_ff    <= '0;
      idx_ff     <= '0;
      shift_ff   <= UARX_DATA_ZERO;
      par_bit_ff <= 1'h0;
    end else begin
      if (in_window) vote_ff <= {vote_ff[0], smp}; // R19
      if (state_ff == UARX_START) idx_ff <= '0;
      else if (state_ff == UARX_DATA && at_end) idx_ff <= idx_ff + 4'h1;
      if (state_ff == UARX_DATA && at_vote) shift_ff <= {maj, shift_ff[UARX_DATA_W-1:1]};
      if (state_ff == UARX_PARITY && at_vote) par_bit_ff <= maj;
    end
  end

  // finished frame waiting in the shift stage
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      pend_ff    <= UARX_ENTRY_ZERO;
      pend_ok_ff <= 1'h0;
    end else if (!en) begin
      pend_ok_ff <= 1'h0; // R12
    end else if (frame_done) begin
      pend_ff.data     <= shift_ff;
      pend_ff.stop_err <= !maj;                      // R05 R20
      pend_ff.par_err  <= PARITY_ENABLE_BIT && par_bad; // R11
      pend_ok_ff       <= 1'h1;
    end else if (overrun || transfer) begin
      pend_ok_ff <= 1'h0; // R07
    end
  end

  // overrun marker carried by the next frame that makes it into the buffer
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) lose_ff <= 1'h0;
    else if (!en) lose_ff <= 1'h0;
    else if (overrun) lose_ff <= 1'h1; // R07
    else if (transfer) lose_ff <= 1'h0; // R08
  end

  // buffer control
  assign buf_bus.push       = transfer;
  assign buf_bus.push_entry = '{pend_ff.data, pend_ff.stop_err, lose_ff, pend_ff.par_err}; // R01
  assign buf_bus.pop        = DATA_READ; // R02 R14
  assign buf_bus.flush      = !en;       // R13

  // registered outputs; flags come only from the buffer head, no write path
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DATA_BUFFER_LOCATION  <= UARX_DATA_ZERO;
      STOP_BIT_ERROR_FLAG   <= 1'h0;
      OVERRUN_FLAG          <= 1'h0;
      PARITY_ERROR_FLAG     <= 1'h0;
      RECEIVE_COMPLETE_FLAG <= 1'h0;
      RXD_OVERRIDE          <= 1'h0;
    end else begin
      DATA_BUFFER_LOCATION  <= buf_bus.not_empty ? buf_bus.head.data : UARX_DATA_ZERO;
      STOP_BIT_ERROR_FLAG   <= buf_bus.not_empty && buf_bus.head.stop_err; // R03 R04
      OVERRUN_FLAG          <= buf_bus.not_empty && buf_bus.head.overrun;
      PARITY_ERROR_FLAG     <= buf_bus.not_empty && buf_bus.head.par_err;
      RECEIVE_COMPLETE_FLAG <= buf_bus.not_empty; // R22
      RXD_OVERRIDE          <= en;                // R12
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_stop_vote;
    state_ff == UARX_STOP && at_vote;
  endsequence

  a_start_reject: assert property ( // R17
    state_ff == UARX_START && at_vote && maj && en |=> state_ff == UARX_IDLE)
    else $error("noisy start bit not rejected");
  a_stop_error: assert property ( // R05
    s_stop_vote and en |=> pend_ok_ff && pend_ff.stop_err == $past(!maj))
    else $error("stop error does not match voted stop bit");
  a_parity_off: assert property ( // R11
    frame_done && !PARITY_ENABLE_BIT |=> !pend_ff.par_err)
    else $error("parity error with checking disabled");
  a_norm_rearm: assert property ( // R21
    s_stop_vote and en && !DOUBLE_SPEED_SELECT |=> state_ff == UARX_IDLE)
    else $error("normal mode not rearmed after stop vote");
  a_dbl_rearm: assert property ( // R23
    s_stop_vote and en && DOUBLE_SPEED_SELECT |=> state_ff == UARX_HOLD)
    else $error("double speed mode rearmed too early");
  a_overrun_set: assert property ( // R07
    overrun |=> lose_ff && !pend_ok_ff)
    else $error("overrun not recorded");
  a_overrun_clear: assert property ( // R08
    transfer && !overrun |=> !lose_ff ##1 OVERRUN_FLAG == $past(buf_bus.head.overrun))
    else $error("overrun marker not cleared on transfer");
  a_tick_only: assert property ( // R24
    !SAMPLE_TICK && en && state_ff != UARX_IDLE |=> $stable(cnt_ff))
    else $error("sample counter moved without a tick");
  a_count_range: assert property ( // R18
    cnt_ff >= UARX_SAMPLE_ONE && cnt_ff <= UARX_LAST_NORM)
    else $error("sample counter out of range");
  a_disable_flush: assert property ( // R13
    !en |=> !RXD_OVERRIDE ##1 !RECEIVE_COMPLETE_FLAG)
    else $error("buffer not flushed on disable");
  a_rxc_level: assert property ( // R22
    RECEIVE_COMPLETE_FLAG == $past(buf_bus.not_empty))
    else $error("receive complete does not track buffer");

  // frame entering an empty buffer becomes the head with its status
  sequence s_push_empty;
    transfer && !buf_bus.not_empty;
  endsequence

  // start bit whose centre vote came out low
  sequence s_start_keep;
    state_ff == UARX_START && at_vote && !maj;
  endsequence

  a_push_head: assert property ( // R01
    s_push_empty |=> buf_bus.head == $past(buf_bus.push_entry))
    else $error("pushed entry not at buffer head");
  a_empty_zero: assert property ( // R22
    !RECEIVE_COMPLETE_FLAG |-> !STOP_BIT_ERROR_FLAG && !OVERRUN_FLAG && !PARITY_ERROR_FLAG
      && DATA_BUFFER_LOCATION == UARX_DATA_ZERO)
    else $error("empty buffer shows data or flags");
  a_parity_on: assert property ( // R10
    frame_done && PARITY_ENABLE_BIT |=>
      pend_ff.par_err == $past(^{shift_ff, par_bit_ff, PARITY_ODD_SELECT}))
    else $error("parity result not stored with frame");
  a_start_keep: assert property ( // R17
    s_start_keep and en |=> state_ff == UARX_START)
    else $error("valid start bit dropped");
  a_start_sample: assert property ( // R16
    start_det |=> state_ff == UARX_START && cnt_ff == UARX_SAMPLE_ONE)
    else $error("start edge not counted as sample one");
  a_bit_vote: assert property ( // R19
    state_ff == UARX_DATA && at_vote |=>
      shift_ff[UARX_DATA_W-1] == $past($countones({vote_ff, smp}) > 1))
    else $error("data bit not decided by majority");
  a_frame_end: assert property ( // R20
    frame_done |=> pend_ok_ff && (state_ff == UARX_IDLE || state_ff == UARX_HOLD))
    else $error("frame not closed at first stop bit");
  a_dbl_range: assert property ( // R15
    DOUBLE_SPEED_SELECT && state_ff != UARX_IDLE |-> cnt_ff <= UARX_LAST_DBL)
    else $error("double speed counter beyond eight states");
  a_disable_idle: assert property ( // R12
    !en |=> state_ff == UARX_IDLE && !pend_ok_ff && !lose_ff)
    else $error("disable did not drop the frame in progress");
  a_disable_empty: assert property ( // R13
    !en |=> !buf_bus.not_empty)
    else $error("disable did not empty the buffer");
  a_sync_lag: assert property ( // R24
    smp == $past(RXD_PIN, 2))
    else $error("serial input not passed through two stages");
endmodule // uarx_core

//--- common/uarx_pkg.sv
// Purpose: shared constants and types of the asynchronous receive core
// Assumes: eight data bits, a sample tick at the oversampling rate
// Notes:   sample numbers count from one at the first low sample
package uarx_pkg;

  localparam int UARX_DATA_W = 8;

  // sample numbering inside one bit, normal and double speed
  localparam logic [4:0] UARX_LAST_NORM  = 5'h10; // sixteen states per bit
  localparam logic [4:0] UARX_LAST_DBL   = 5'h08; // eight states per bit
  localparam logic [4:0] UARX_VOTE1_NORM = 5'h08; // first centre sample
  localparam logic [4:0] UARX_VOTEN_NORM = 5'h0A; // last centre sample
  localparam logic [4:0] UARX_VOTE1_DBL  = 5'h04;
  localparam logic [4:0] UARX_VOTEN_DBL  = 5'h06;
  localparam logic [4:0] UARX_SAMPLE_ONE = 5'h01;

  localparam logic       UARX_LINE_IDLE  = 1'h1;
  localparam logic [UARX_DATA_W-1:0] UARX_DATA_ZERO = 8'h00;

  // one receive buffer entry: character plus its own status
  typedef struct packed {
    logic [UARX_DATA_W-1:0] data;
    logic                   stop_err;
    logic                   overrun;
    logic                   par_err;
  } uarx_entry_type;

  localparam uarx_entry_type UARX_ENTRY_ZERO = '{UARX_DATA_ZERO, 1'h0, 1'h0, 1'h0};

  typedef enum logic [2:0] {
    UARX_IDLE   = 3'h0,
    UARX_START  = 3'h1,
    UARX_DATA   = 3'h2,
    UARX_PARITY = 3'h3,
    UARX_STOP   = 3'h4,
    UARX_HOLD   = 3'h5
  } uarx_state_type;

endpackage

//--- common/uarx_buf_if.sv
// Purpose: carries pushes and pops to the receive buffer and the head entry back from it
// Assumes: one clock shared by both ends
// Notes:   flush empties the buffer in one cycle
`timescale 1ns/1ps
interface uarx_buf_if;
  import uarx_pkg::*;
  logic           push;
  uarx_entry_type push_entry;
  logic           pop;
  logic           flush;
  logic           full;
  logic           not_empty;
  uarx_entry_type head;

  modport writer (output push, push_entry, pop, flush, input full, not_empty, head);
  modport store  (input push, push_entry, pop, flush, output full, not_empty, head);
endinterface

//--- logic/uarx_sync.sv
// Purpose: brings the serial input into the core clock domain
// Assumes: line idles high
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module uarx_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic din,
  output logic      dout
);
  import uarx_pkg::*;

  logic meta_ff;

  // two-stage synchroniser, resets to the idle level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= UARX_LINE_IDLE;
      dout    <= UARX_LINE_IDLE;
    end else begin
      meta_ff <= din;
      dout    <= meta_ff;
    end
  end
endmodule // uarx_sync

//--- logic/uarx_rxbuf.sv
// Purpose: receive buffer holding characters with their status
// Assumes: writer never pushes while full
// Notes:   flush beats push and pop in the same cycle
`timescale 1ns/1ps
module uarx_rxbuf #(
  parameter int DEPTH = 2
) (
  input  wire logic clk,
  input  wire logic rst_n,
  uarx_buf_if.store bus
);
  import uarx_pkg::*;

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] CNT_FULL = (PW+1)'(DEPTH); // fill level fits the wider count

  uarx_entry_type mem_ff [DEPTH];
  logic [PW-1:0]  wr_ff;
  logic [PW-1:0]  rd_ff;
  logic [PW:0]    cnt_ff;

  wire do_push = bus.push && !bus.full;
  wire do_pop  = bus.pop && bus.not_empty;

  assign bus.full      = (cnt_ff == CNT_FULL);
  assign bus.not_empty = (cnt_ff != '0);
  assign bus.head      = mem_ff[rd_ff];

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    bump = (p == PW'(DEPTH - 1)) ? '0 : p + 1'h1;
  endfunction

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else if (bus.flush) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (do_push) wr_ff <= bump(wr_ff);
      if (do_pop) rd_ff <= bump(rd_ff);
      cnt_ff <= cnt_ff + (do_push ? 1'h1 : 1'h0) - (do_pop ? 1'h1 : 1'h0);
    end
  end

  // storage, one slot per entry
  for (genvar i = 0; i < DEPTH; i++) begin : g_slot
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) mem_ff[i] <= UARX_ENTRY_ZERO;
      else if (do_push && wr_ff == PW'(i)) mem_ff[i] <= bus.push_entry;
    end
  end
endmodule // uarx_rxbuf

//--- testbench/uarx_tx_model.sv
// Purpose: remote serial transmitter driving the receive line
// Assumes: bit time is a whole number of sample ticks
// Notes:   line rests high between frames, the level of an idle pulled-up line
`timescale 1ns/1ps
module uarx_tx_model (
  input  wire logic clk,
  input  wire logic tick,
  output logic      rxd
);
  initial rxd = 1'b1;

  // waits for the given number of sample ticks
  task automatic wait_ticks(input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      while (tick !== 1'b1) @(posedge clk);
    end
  endtask

  // start, data lsb first, optional parity, one stop bit, then idle
  task automatic send(input logic [7:0] d, input int spb, input logic pe,
                      input logic odd, input logic bp, input logic bs);
    logic [10:0] bits;
    int          n;
    n    = pe ? 11 : 10;
    bits = pe ? {~bs, (^d) ^ odd ^ bp, d, 1'b0} : {1'b1, ~bs, d, 1'b0};
    for (int i = 0; i < n; i++) begin
      rxd <= bits[i];
      wait_ticks(spb);
    end
    rxd <= 1'b1;
  endtask

  // short low pulse that must not pass for a start bit
  task automatic glitch(input int k, input int spb);
    rxd <= 1'b0;
    wait_ticks(k);
    rxd <= 1'b1;
    wait_ticks(spb);
  endtask
endmodule // uarx_tx_model

//--- testbench/uarx_core_bench.sv
// Purpose: self-checking bench of the receive core
// Assumes: sample tick every fourth clock
// Notes:   a monitor reads status then data whenever a character waits and hold_reads is low
`timescale 1ns/1ps
module uarx_core_bench;
  import uarx_pkg::*;
  logic                   CORE_CLK, RESET_N, SAMPLE_TICK, RXD_PIN, DATA_READ;
  logic                   RECEIVER_ENABLE_BIT, DOUBLE_SPEED_SELECT;
  logic                   PARITY_ENABLE_BIT, PARITY_ODD_SELECT;
  logic [UARX_DATA_W-1:0] DATA_BUFFER_LOCATION;
  logic                   STOP_BIT_ERROR_FLAG, OVERRUN_FLAG, PARITY_ERROR_FLAG;
  logic                   RECEIVE_COMPLETE_FLAG, RXD_OVERRIDE, hold_reads;
  int                     err_count, total_checks, cycles, div;
  uarx_entry_type         exp_q[$];
  uarx_entry_type         got;

  uarx_core u_uarx_core (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .RXD_PIN(RXD_PIN),
    .SAMPLE_TICK(SAMPLE_TICK), .RECEIVER_ENABLE_BIT(RECEIVER_ENABLE_BIT),
    .DOUBLE_SPEED_SELECT(DOUBLE_SPEED_SELECT), .PARITY_ENABLE_BIT(PARITY_ENABLE_BIT),
    .PARITY_ODD_SELECT(PARITY_ODD_SELECT), .DATA_READ(DATA_READ),
    .DATA_BUFFER_LOCATION(DATA_BUFFER_LOCATION), .STOP_BIT_ERROR_FLAG(STOP_BIT_ERROR_FLAG),
    .OVERRUN_FLAG(OVERRUN_FLAG), .PARITY_ERROR_FLAG(PARITY_ERROR_FLAG),
    .RECEIVE_COMPLETE_FLAG(RECEIVE_COMPLETE_FLAG), .RXD_OVERRIDE(RXD_OVERRIDE));
  uarx_tx_model u_uarx_tx_model (.clk(CORE_CLK), .tick(SAMPLE_TICK), .rxd(RXD_PIN));

  // clock source
  initial begin
    CORE_CLK = 1'b0;
    forever #5 CORE_CLK = ~CORE_CLK;
  end

  // sample tick, cycle count and hang guard
  always @(posedge CORE_CLK) begin
    div         <= (div == 3) ? 0 : div + 1;
    SAMPLE_TICK <= (div == 3);
    cycles      <= cycles + 1;
    if (cycles == 80000) begin
      err_count++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      err_count++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  // sends one frame at the current settings, noting the expected entry if kept
  task automatic frame(input logic [7:0] d, input logic bp, input logic bs,
                       input logic ovr, input logic keep);
    if (keep) exp_q.push_back('{d, bs, ovr, bp & PARITY_ENABLE_BIT});
    u_uarx_tx_model.send(d, DOUBLE_SPEED_SELECT ? 8 : 16, PARITY_ENABLE_BIT,
                         PARITY_ODD_SELECT, bp, bs);
  endtask

  // waits until every noted character has been read back
  task automatic drain;
    int n;
    n = 0;
    while ((exp_q.size() != 0 || RECEIVE_COMPLETE_FLAG !== 1'b0) && n < 5000) begin
      @(posedge CORE_CLK);
      n++;
    end
    repeat (4) @(posedge CORE_CLK);
    check(exp_q.size() == 0 && RECEIVE_COMPLETE_FLAG === 1'b0, "buffer not empty");
  endtask

  // monitor: compare the head entry, then read the data location
  initial begin
    DATA_READ = 1'b0;
    forever begin
      @(posedge CORE_CLK);
      if (RECEIVE_COMPLETE_FLAG === 1'b1 && hold_reads === 1'b0) begin
        got = '{DATA_BUFFER_LOCATION, STOP_BIT_ERROR_FLAG, OVERRUN_FLAG, PARITY_ERROR_FLAG};
        check(exp_q.size() > 0 && got === exp_q[0], "wrong character or status");
        if (exp_q.size() > 0) got = exp_q.pop_front();
        DATA_READ <= 1'b1;
        @(posedge CORE_CLK);
        DATA_READ <= 1'b0;
        repeat (2) @(posedge CORE_CLK);
      end
    end
  end

  // main sequence
  initial begin
    err_count = 0;
    total_checks = 0;
    cycles = 0;
    div = 0;
    RESET_N = 1'b0;
    SAMPLE_TICK = 1'b0;
    RECEIVER_ENABLE_BIT = 1'b1;
    DOUBLE_SPEED_SELECT = 1'b0;
    PARITY_ENABLE_BIT = 1'b0;
    PARITY_ODD_SELECT = 1'b0;
    hold_reads = 1'b0;
    void'($urandom(32'h4b06));
    repeat (5) @(posedge CORE_CLK);
    RESET_N <= 1'b1;
    repeat (4) @(posedge CORE_CLK);
    check(RXD_OVERRIDE === 1'b1 && RECEIVE_COMPLETE_FLAG === 1'b0, "idle after reset");
    // every speed and parity mode; boundary glitch, then good and bad frames
    for (int m = 0; m < 16; m++) begin
      DOUBLE_SPEED_SELECT <= m[0];
      PARITY_ENABLE_BIT   <= m[1];
      PARITY_ODD_SELECT   <= m[2];
      @(posedge CORE_CLK);
      u_uarx_tx_model.glitch(m[0] ? 4 : 8, 16);
      frame(8'($urandom), 1'b0, 1'b0, 1'b0, 1'b1);
      frame(8'($urandom), m[3], m[3] ^ m[2], 1'b0, 1'b1);
      drain();
    end
    // four frames into a full buffer: third is lost, fourth carries overrun
    DOUBLE_SPEED_SELECT <= 1'b0;
    PARITY_ENABLE_BIT   <= 1'b0;
    hold_reads          <= 1'b1;
    @(posedge CORE_CLK);
    frame(8'h5a, 1'b0, 1'b0, 1'b0, 1'b1);
    frame(8'ha5, 1'b0, 1'b0, 1'b0, 1'b1);
    frame(8'h3c, 1'b0, 1'b0, 1'b0, 1'b0);
    frame(8'hc3, 1'b0, 1'b0, 1'b1, 1'b1);
    repeat (20) @(posedge CORE_CLK);
    check(RECEIVE_COMPLETE_FLAG === 1'b1 && OVERRUN_FLAG === 1'b0, "full buffer head");
    hold_reads <= 1'b0;
    drain();
    frame(8'h81, 1'b0, 1'b0, 1'b0, 1'b1);
    drain();
    // disable with two characters held and a third in flight
    hold_reads <= 1'b1;
    frame(8'h11, 1'b0, 1'b0, 1'b0, 1'b0);
    frame(8'h22, 1'b0, 1'b0, 1'b0, 1'b0);
    fork
      frame(8'h33, 1'b0, 1'b0, 1'b0, 1'b0);
    join_none
    repeat (200) @(posedge CORE_CLK);
    RECEIVER_ENABLE_BIT <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    check(RECEIVE_COMPLETE_FLAG === 1'b0 && RXD_OVERRIDE === 1'b0, "not flushed");
    check(DATA_BUFFER_LOCATION === UARX_DATA_ZERO, "stale data");
    repeat (800) @(posedge CORE_CLK);
    RECEIVER_ENABLE_BIT <= 1'b1;
    hold_reads          <= 1'b0;
    repeat (4) @(posedge CORE_CLK);
    frame(8'he7, 1'b0, 1'b0, 1'b0, 1'b1);
    drain();
    results();
  end
endmodule // uarx_core_bench
